// ==== rtl/acreg_map.svh ====
// Summary of operation
// - Each tight memory control word shows a read-only size code, zero meaning none.
// - Tight memory enable clear sends that memory's accesses to the AXI master.
// - Retry-phase enable set passes the tight memory retry output through.
// - Merge enable set makes every sub-chunk write a read-modify-write.
// - Tight memory enables may be preset at reset from input pins.
// - Retry and merge enables may be preset at reset from input pins.
// - Peripheral port word shows a read-only size code and an enable.
// - Peripheral port enable may be preset at reset from an input pin.
// - Forced write-through makes write-back regions write-through; zero without data cache.
// - Cache check control written 0 enables cache ECC, written 1 disables it.
// - Cache check control ignores writes without ECC; resets 0 with ECC, else 1.
// - Override clear treats shared cacheable locations as non-cacheable.
// - Override set makes shared data write-through, shared instructions non-cacheable.
// - Fairness initial value is read-write and resets to one.
// - Fairness value zero is forbidden; the counter is unused when select is three.
// - Master port response type field is valid only while its fault flag is set.
// - Fault flags hold until a privileged write to the fault status word clears them.
// - Fault bit zero flags an instruction tight memory fault.
`ifndef ACREG_MAP_SVH
`define ACREG_MAP_SVH
`define ACREG_OFF_ITIGHT     32'hE000EF90
`define ACREG_OFF_DTIGHT     32'hE000EF94
`define ACREG_OFF_PERIPH     32'hE000EF98
`define ACREG_OFF_CACHE      32'hE000EF9C
`define ACREG_OFF_FAULT      32'hE000EFA0
`define ACREG_OFF_SLAVE_PRIO 32'hE000EFA4
`define ACREG_WORD_ZERO      32'h00000000
`define ACREG_TCM_EN         0
`define ACREG_TCM_MERGE      1
`define ACREG_TCM_RETRY      2
`define ACREG_TCM_SIZE_LO    3
`define ACREG_TCM_SIZE_HI    6
`define ACREG_TCM_SIZE_DEF   4'h0
`define ACREG_PER_EN         0
`define ACREG_PER_SIZE_LO    1
`define ACREG_PER_SIZE_HI    3
`define ACREG_PER_SIZE_DEF   3'h1
`define ACREG_CA_SHARED      0
`define ACREG_CA_CHECK       1
`define ACREG_CA_FWT         2
`define ACREG_PR_SEL_LO      0
`define ACREG_PR_SEL_HI      1
`define ACREG_PR_TP_LO       2
`define ACREG_PR_TP_HI       10
`define ACREG_PR_INIT_LO     11
`define ACREG_PR_INIT_HI     15
`define ACREG_PR_INIT_RST    5'h01
`define ACREG_PR_SEL_RST     2'h0
`define ACREG_PR_TP_RST      9'h000
`define ACREG_PR_SEL_NOUSE   2'h3
`define ACREG_FLT_ITIGHT     0
`define ACREG_FLT_DTIGHT     1
`define ACREG_FLT_PERIPH     2
`define ACREG_FLT_PPB        3
`define ACREG_FLT_MASTER     4
`define ACREG_FLT_W          5
`define ACREG_FLT_TYPE_LO    8
`define ACREG_FLT_TYPE_HI    9
`define ACREG_NUM_TIGHT      2
`endif

// ==== rtl/acreg_pkg.sv ====
package acreg_pkg;
	typedef logic [31:0] acreg_word_t;
	typedef logic [3:0]  acreg_tcm_size_t;
	typedef logic [2:0]  acreg_per_size_t;
	typedef enum logic [1:0] {
		ACREG_RESP_OKAY   = 2'h0,
		ACREG_RESP_EXOKAY = 2'h1,
		ACREG_RESP_SLVERR = 2'h2,
		ACREG_RESP_DECERR = 2'h3
	} acreg_resp_t;
	typedef logic [4:0] acreg_flags_t;
endpackage

// ==== rtl/acreg_fault_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface acreg_fault_if;
	acreg_pkg::acreg_flags_t event_pulse;
	acreg_pkg::acreg_resp_t  master_resp;
	logic                    clear_pulse;
	acreg_pkg::acreg_flags_t flags;
	acreg_pkg::acreg_resp_t  master_type;
	modport owner (
		input  event_pulse,
		input  master_resp,
		input  clear_pulse,
		output flags,
		output master_type
	);
	modport user (
		output event_pulse,
		output master_resp,
		output clear_pulse,
		input  flags,
		input  master_type
	);
endinterface
`default_nettype wire

// ==== rtl/acreg_fault_capture.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acreg_map.svh"
module acreg_fault_capture (
	input  wire logic         clk,
	input  wire logic         rst_sync_n,
	input  wire logic         clk_en,
	acreg_fault_if.owner      flt
);
	acreg_pkg::acreg_flags_t flags_reg;
	acreg_pkg::acreg_flags_t flags_next;
	acreg_pkg::acreg_resp_t  type_reg;
	acreg_pkg::acreg_resp_t  type_next;
	wire logic               master_event;

	assign master_event = flt.event_pulse[`ACREG_FLT_MASTER];
	// A fault arriving with the clearing write survives it.
	assign flags_next = (flt.clear_pulse ? '0 : flags_reg) | flt.event_pulse;
	// The type follows the latest master fault and drops with the flag.
	assign type_next = master_event ? flt.master_resp :
		(flt.clear_pulse ? acreg_pkg::ACREG_RESP_OKAY : type_reg);

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flags_reg <= '0;
			type_reg  <= acreg_pkg::ACREG_RESP_OKAY;
		end else if (clk_en) begin
			flags_reg <= flags_next;
			type_reg  <= type_next;
		end
	end

	assign flt.flags       = flags_reg;
	assign flt.master_type = type_reg;
endmodule
`default_nettype wire

// ==== rtl/acreg_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acreg_map.svh"
module acreg_regs #(
	parameter logic [3:0] ITIGHT_SIZE = `ACREG_TCM_SIZE_DEF,
	parameter logic [3:0] DTIGHT_SIZE = `ACREG_TCM_SIZE_DEF,
	parameter logic [2:0] PERIPH_SIZE = `ACREG_PER_SIZE_DEF,
	parameter bit         HAS_DCACHE  = 1'b1,
	parameter bit         HAS_ICACHE  = 1'b1,
	parameter bit         HAS_ECC     = 1'b1
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        ppb_sel,
	input  wire logic        ppb_write,
	input  wire logic        ppb_priv,
	input  wire logic [31:0] ppb_addr,
	input  wire logic [31:0] ppb_wdata,
	output logic             ppb_ack,
	output logic             ppb_err,
	output logic      [31:0] ppb_rdata,
	input  wire logic [1:0]  tight_en_strap,
	input  wire logic [1:0]  retry_en_strap,
	input  wire logic [1:0]  merge_en_strap,
	input  wire logic        periph_en_strap,
	input  wire logic [1:0]  tight_region_hit,
	input  wire logic        periph_region_hit,
	output logic      [1:0]  route_tight,
	output logic             route_periph,
	output logic             route_master,
	input  wire logic [1:0]  tight_retry_in,
	output logic      [1:0]  tight_retry_honour,
	input  wire logic [1:0]  tight_subchunk_write,
	output logic      [1:0]  tight_merge_req,
	input  wire logic        attr_cacheable,
	input  wire logic        attr_shared,
	input  wire logic        attr_write_back,
	output logic             dcache_cacheable,
	output logic             dcache_write_through,
	output logic             icache_cacheable,
	output logic             cache_check_on,
	output logic      [4:0]  fairness_initial_value,
	output logic      [1:0]  requester_select,
	output logic      [8:0]  traffic_priority,
	output logic             fairness_counter_used,
	input  wire logic [4:0]  bus_fault_event,
	input  wire logic [1:0]  master_port_resp,
	output logic      [4:0]  aux_fault_flags
);
	localparam bit ANY_CACHE = HAS_DCACHE | HAS_ICACHE;
	localparam bit CHECK_WR  = ANY_CACHE & HAS_ECC;
	localparam bit CHECK_RST = ~HAS_ECC;
	localparam int NT        = `ACREG_NUM_TIGHT;

	logic        rst_meta_reg;
	logic        rst_sync_reg;
	logic        strap_done_reg;
	logic [2:0]  tight_ctrl_reg [NT];
	logic        periph_en_reg;
	logic        fwt_reg;
	logic        check_reg;
	logic        shared_reg;
	logic [4:0]  init_reg;
	logic [8:0]  tprio_reg;
	logic [1:0]  sel_reg;
	logic        ack_reg;
	logic        err_reg;
	acreg_pkg::acreg_word_t rdata_reg;
	acreg_pkg::acreg_word_t rdata_next;

	wire logic        hit_itight;
	wire logic        hit_dtight;
	wire logic        hit_periph;
	wire logic        hit_cache;
	wire logic        hit_fault;
	wire logic        hit_prio;
	wire logic        hit_any;
	wire logic        take;
	wire logic        wr_ok;
	wire logic        rd_ok;
	wire logic [NT-1:0] wr_tight;
	wire logic        wr_periph;
	wire logic        wr_cache;
	wire logic        wr_fault;
	wire logic        wr_prio;
	wire logic [3:0]  tight_size [NT];
	acreg_pkg::acreg_word_t tight_word [NT];
	acreg_pkg::acreg_word_t periph_word;
	acreg_pkg::acreg_word_t cache_word;
	acreg_pkg::acreg_word_t fault_word;
	acreg_pkg::acreg_word_t prio_word;
	wire logic [NT-1:0] tight_en;
	wire logic        shared_access;

	acreg_fault_if flt ();

	// The reset is released through two stages to keep the release clean.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign hit_itight = ppb_addr == `ACREG_OFF_ITIGHT;
	assign hit_dtight = ppb_addr == `ACREG_OFF_DTIGHT;
	assign hit_periph = ppb_addr == `ACREG_OFF_PERIPH;
	assign hit_cache  = ppb_addr == `ACREG_OFF_CACHE;
	assign hit_fault  = ppb_addr == `ACREG_OFF_FAULT;
	assign hit_prio   = ppb_addr == `ACREG_OFF_SLAVE_PRIO;
	assign hit_any    = hit_itight | hit_dtight | hit_periph | hit_cache | hit_fault | hit_prio;
	// Requests are only honoured once the pin presets have been taken.
	assign take       = clk_en & ppb_sel & strap_done_reg;
	assign wr_ok      = take & ppb_write & ppb_priv & hit_any;
	assign rd_ok      = take & ~ppb_write & ppb_priv & hit_any;
	assign wr_tight   = {wr_ok & hit_dtight, wr_ok & hit_itight};
	assign wr_periph  = wr_ok & hit_periph;
	assign wr_cache   = wr_ok & hit_cache;
	assign wr_fault   = wr_ok & hit_fault;
	assign wr_prio    = wr_ok & hit_prio;
	assign tight_size[0] = ITIGHT_SIZE;
	assign tight_size[1] = DTIGHT_SIZE;

	// Pin presets are caught on the first enabled edge after release.
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			strap_done_reg <= 1'b0;
		end else if (clk_en) begin
			strap_done_reg <= 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++) begin : g_tight
			always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
				if (!rst_sync_reg) begin
					tight_ctrl_reg[gi] <= 3'h0;
				end else if (clk_en && !strap_done_reg) begin
					tight_ctrl_reg[gi][`ACREG_TCM_EN]    <= tight_en_strap[gi];
					tight_ctrl_reg[gi][`ACREG_TCM_MERGE] <= merge_en_strap[gi];
					tight_ctrl_reg[gi][`ACREG_TCM_RETRY] <= retry_en_strap[gi];
				end else if (wr_tight[gi]) begin
					tight_ctrl_reg[gi] <= ppb_wdata[`ACREG_TCM_RETRY:`ACREG_TCM_EN];
				end
			end

			assign tight_en[gi] = tight_ctrl_reg[gi][`ACREG_TCM_EN];
			// Size is fixed by the build and cannot be written.
			assign tight_word[gi] = {
				{(32 - `ACREG_TCM_SIZE_HI - 1){1'b0}},
				tight_size[gi],
				tight_ctrl_reg[gi]
			};
			// A disabled tight memory hands its region to the AXI master.
			assign route_tight[gi] = tight_region_hit[gi] & tight_en[gi];
			assign tight_retry_honour[gi] =
				tight_retry_in[gi] & tight_ctrl_reg[gi][`ACREG_TCM_RETRY];
			assign tight_merge_req[gi] =
				tight_subchunk_write[gi] & tight_ctrl_reg[gi][`ACREG_TCM_MERGE];
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			periph_en_reg <= 1'b0;
		end else if (clk_en && !strap_done_reg) begin
			periph_en_reg <= periph_en_strap;
		end else if (wr_periph) begin
			periph_en_reg <= ppb_wdata[`ACREG_PER_EN];
		end
	end

	assign periph_word = {
		{(32 - `ACREG_PER_SIZE_HI - 1){1'b0}},
		PERIPH_SIZE,
		periph_en_reg
	};
	assign route_periph = periph_region_hit & periph_en_reg;
	assign route_master = (|(tight_region_hit & ~tight_en)) |
		(periph_region_hit & ~periph_en_reg);

	// Without a data cache the two data-side bits are held at zero.
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			fwt_reg    <= 1'b0;
			shared_reg <= 1'b0;
			check_reg  <= CHECK_RST;
		end else if (wr_cache) begin
			fwt_reg    <= ppb_wdata[`ACREG_CA_FWT] & HAS_DCACHE;
			shared_reg <= ppb_wdata[`ACREG_CA_SHARED] & HAS_DCACHE;
			if (CHECK_WR) begin
				check_reg <= ppb_wdata[`ACREG_CA_CHECK];
			end
		end
	end

	assign cache_word = {
		{(32 - `ACREG_CA_FWT - 1){1'b0}},
		fwt_reg,
		check_reg,
		shared_reg
	};

	// Changing this bit with live cache lines is unsafe; software must flush first.
	assign cache_check_on = HAS_ECC & ~check_reg;
	assign shared_access  = attr_cacheable & attr_shared;
	// Clear override makes shared lines bypass the caches entirely.
	assign dcache_cacheable = attr_cacheable & (~attr_shared | shared_reg) & HAS_DCACHE;
	// Set override keeps shared data but forces it write-through.
	assign dcache_write_through = dcache_cacheable &
		((fwt_reg & attr_write_back) | (shared_access & shared_reg) | ~attr_write_back);
	assign icache_cacheable = attr_cacheable & ~attr_shared & HAS_ICACHE;

	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			init_reg  <= `ACREG_PR_INIT_RST;
			tprio_reg <= `ACREG_PR_TP_RST;
			sel_reg   <= `ACREG_PR_SEL_RST;
		end else if (wr_prio) begin
			init_reg  <= ppb_wdata[`ACREG_PR_INIT_HI:`ACREG_PR_INIT_LO];
			tprio_reg <= ppb_wdata[`ACREG_PR_TP_HI:`ACREG_PR_TP_LO];
			sel_reg   <= ppb_wdata[`ACREG_PR_SEL_HI:`ACREG_PR_SEL_LO];
		end
	end

	// A zero value is stored as written; the arbiter must not be handed it.
	assign prio_word = {
		{(32 - `ACREG_PR_INIT_HI - 1){1'b0}},
		init_reg,
		tprio_reg,
		sel_reg
	};
	assign fairness_initial_value = init_reg;
	assign requester_select       = sel_reg;
	assign traffic_priority       = tprio_reg;
	assign fairness_counter_used  = sel_reg != `ACREG_PR_SEL_NOUSE;

	assign flt.event_pulse = clk_en ? bus_fault_event : '0;
	assign flt.master_resp = acreg_pkg::acreg_resp_t'(master_port_resp);
	assign flt.clear_pulse = wr_fault;

	acreg_fault_capture u_fault (
		.clk        (sys_clk),
		.rst_sync_n (rst_sync_reg),
		.clk_en     (clk_en),
		.flt        (flt)
	);

	// The type field shows only while the master port flag stands.
	assign fault_word = {
		{(32 - `ACREG_FLT_TYPE_HI - 1){1'b0}},
		flt.flags[`ACREG_FLT_MASTER] ? flt.master_type : acreg_pkg::ACREG_RESP_OKAY,
		{(`ACREG_FLT_TYPE_LO - `ACREG_FLT_W){1'b0}},
		flt.flags
	};
	assign aux_fault_flags = flt.flags;

	assign rdata_next =
		hit_itight ? tight_word[0] :
		hit_dtight ? tight_word[1] :
		hit_periph ? periph_word :
		hit_cache  ? cache_word :
		hit_fault  ? fault_word :
		hit_prio   ? prio_word : `ACREG_WORD_ZERO;

	// Answers are registered so read data always comes from a flip-flop.
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ack_reg   <= 1'b0;
			err_reg   <= 1'b0;
			rdata_reg <= `ACREG_WORD_ZERO;
		end else if (clk_en) begin
			ack_reg   <= take;
			err_reg   <= take & ~(ppb_priv & hit_any);
			rdata_reg <= rd_ok ? rdata_next : `ACREG_WORD_ZERO;
		end
	end

	assign ppb_ack   = ack_reg;
	assign ppb_err   = err_reg;
	assign ppb_rdata = rdata_reg;
endmodule
`default_nettype wire

// ==== testbench/acreg_regs_props.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acreg_map.svh"
module acreg_regs_props #(
	parameter logic [3:0] ITIGHT_SIZE = 4'h0,
	parameter bit         HAS_ECC     = 1'b1
) (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        ppb_sel,
	input wire logic        ppb_write,
	input wire logic        ppb_priv,
	input wire logic [31:0] ppb_addr,
	input wire logic [31:0] ppb_wdata,
	input wire logic        ppb_ack,
	input wire logic        ppb_err,
	input wire logic [31:0] ppb_rdata,
	input wire logic [1:0]  tight_region_hit,
	input wire logic [1:0]  route_tight,
	input wire logic [1:0]  tight_retry_in,
	input wire logic [1:0]  tight_retry_honour,
	input wire logic [1:0]  tight_subchunk_write,
	input wire logic [1:0]  tight_merge_req,
	input wire logic        cache_check_on,
	input wire logic [1:0]  requester_select,
	input wire logic        fairness_counter_used,
	input wire logic [4:0]  bus_fault_event,
	input wire logic [4:0]  aux_fault_flags
);
	wire logic take = clk_en && ppb_sel;
	wire logic wr_ok = take && ppb_write && ppb_priv;
	wire logic clr = wr_ok && ppb_addr == `ACREG_OFF_FAULT;
	wire logic bad = take && (!ppb_priv || ppb_addr > `ACREG_OFF_SLAVE_PRIO
		|| ppb_addr < `ACREG_OFF_ITIGHT);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd(a);
		take && !ppb_write && ppb_priv && ppb_addr == a ##1 ppb_ack;
	endsequence
	AST_BAD_ERR: assert property (bad |=> ppb_ack && ppb_err && ppb_rdata == 32'h0)
		else $error("refused access not flagged");
	AST_ITIGHT_SIZE: assert property (s_rd(`ACREG_OFF_ITIGHT) |->
		ppb_rdata[6:3] == ITIGHT_SIZE && ppb_rdata[31:7] == 25'h0) else $error("size field wrong");
	AST_RETRY_GATE: assert property ((tight_retry_honour & ~tight_retry_in) == 2'h0)
		else $error("retry honoured without retry");
	AST_MERGE_GATE: assert property ((tight_merge_req & ~tight_subchunk_write) == 2'h0)
		else $error("merge without sub-chunk write");
	AST_ROUTE_HIT: assert property ((route_tight & ~tight_region_hit) == 2'h0)
		else $error("tight route outside region");
	AST_CHECK_WR: assert property (wr_ok && ppb_addr == `ACREG_OFF_CACHE |=>
		cache_check_on == (HAS_ECC && !$past(ppb_wdata[1]))) else $error("check control wrong");
	AST_FAIR_USED: assert property (fairness_counter_used == (requester_select != 2'h3))
		else $error("fairness use wrong");
	AST_FLT_SET: assert property (clk_en && bus_fault_event != 5'h0 |=>
		(aux_fault_flags & $past(bus_fault_event)) == $past(bus_fault_event))
		else $error("fault flag not set");
	AST_FLT_HOLD: assert property (!clr |=>
		(aux_fault_flags & $past(aux_fault_flags)) == $past(aux_fault_flags))
		else $error("fault flag lost");
	AST_FLT_CLR: assert property (clr && bus_fault_event == 5'h0 |=> aux_fault_flags == 5'h0)
		else $error("fault flags not cleared");
	AST_TYPE_ZERO: assert property (s_rd(`ACREG_OFF_FAULT) ##0 !aux_fault_flags[4]
		&& !$past(aux_fault_flags[4]) |-> ppb_rdata[31:8] == 24'h0) else $error("type field set");
endmodule
bind acreg_regs acreg_regs_props #(.ITIGHT_SIZE(ITIGHT_SIZE), .HAS_ECC(HAS_ECC)) u_acreg_regs_props (
	.sys_clk, .rst_n, .clk_en, .ppb_sel, .ppb_write, .ppb_priv, .ppb_addr, .ppb_wdata,
	.ppb_ack, .ppb_err, .ppb_rdata, .tight_region_hit, .route_tight, .tight_retry_in,
	.tight_retry_honour, .tight_subchunk_write, .tight_merge_req, .cache_check_on,
	.requester_select, .fairness_counter_used, .bus_fault_event, .aux_fault_flags);
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "acreg_map.svh"
module testbench;
	localparam logic [3:0] ISZ = 4'h3;
	localparam logic [3:0] DSZ = 4'hF;
	localparam logic [2:0] PSZ = 3'h4;
	logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
	logic        ppb_sel = 1'b0, ppb_write = 1'b0, ppb_priv = 1'b0;
	logic [31:0] ppb_addr = 32'h0, ppb_wdata = 32'h0, ppb_rdata;
	logic        ppb_ack, ppb_err, route_periph, route_master, periph_en_strap = 1'b0;
	logic [1:0]  tight_en_strap = 2'h0, retry_en_strap = 2'h0, merge_en_strap = 2'h0;
	logic [1:0]  tight_region_hit = 2'h0, tight_retry_in = 2'h0, tight_subchunk_write = 2'h0;
	logic        periph_region_hit = 1'b0, attr_cacheable = 1'b0, attr_shared = 1'b0;
	logic        attr_write_back = 1'b0, dcache_cacheable, dcache_write_through;
	logic        icache_cacheable, cache_check_on, fairness_counter_used;
	logic [1:0]  route_tight, tight_retry_honour, tight_merge_req, requester_select;
	logic [1:0]  master_port_resp = 2'h0, mt;
	logic [4:0]  fairness_initial_value, bus_fault_event = 5'h0, aux_fault_flags, mf;
	logic [8:0]  traffic_priority;
	logic [31:0] m [6];
	logic [31:0] seed = 32'h9B44;
	int          n_errors = 0, samples_checked = 0;
	acreg_regs #(.ITIGHT_SIZE(ISZ), .DTIGHT_SIZE(DSZ), .PERIPH_SIZE(PSZ)) u_acreg_regs (
		.sys_clk, .rst_n, .clk_en, .ppb_sel, .ppb_write, .ppb_priv, .ppb_addr, .ppb_wdata,
		.ppb_ack, .ppb_err, .ppb_rdata, .tight_en_strap, .retry_en_strap, .merge_en_strap,
		.periph_en_strap, .tight_region_hit, .periph_region_hit, .route_tight, .route_periph,
		.route_master, .tight_retry_in, .tight_retry_honour, .tight_subchunk_write,
		.tight_merge_req, .attr_cacheable, .attr_shared, .attr_write_back, .dcache_cacheable,
		.dcache_write_through, .icache_cacheable, .cache_check_on, .fairness_initial_value,
		.requester_select, .traffic_priority, .fairness_counter_used, .bus_fault_event,
		.master_port_resp, .aux_fault_flags);
	always #5 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] ad(input int i);
		return `ACREG_OFF_ITIGHT + 32'(4 * i);
	endfunction
	function automatic logic [31:0] exp_rd(input int i);
		case (i)
			0: return {25'h0, ISZ, m[0][2:0]};
			1: return {25'h0, DSZ, m[1][2:0]};
			2: return {28'h0, PSZ, m[2][0]};
			3: return {29'h0, m[3][2:0]};
			4: return {22'h0, mf[4] ? mt : 2'h0, 3'h0, mf};
			default: return {16'h0, m[5][15:0]};
		endcase
	endfunction
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask
	// The request stands for exactly one taking edge; holding it longer would be a second request.
	task automatic bus(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		ppb_sel = 1'b1;
		ppb_write = w;
		ppb_priv = p;
		ppb_addr = a;
		ppb_wdata = d;
		@(posedge sys_clk);
		#1;
		ppb_sel = 1'b0;
		bus_fault_event = 5'h0;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (ppb_ack !== 1'b1 && k < 4);
		q = ppb_rdata;
		e = ppb_err;
		if (ppb_ack !== 1'b1) begin
			$display("[ERR] ack expected 1 seen %b", ppb_ack);
			n_errors++;
			results();
		end
		#1;
	endtask
	task automatic rreg(input int i);
		logic [31:0] q;
		logic        e;
		bus(1'b0, 1'b1, ad(i), xs(), q, e);
		chk("read", q, exp_rd(i));
		chk("read_err", e, 1'b0);
		if (i == 4)
			chk("flags", aux_fault_flags, mf);
	endtask
	// A write in the same cycle as a fault event leaves that event's flag set.
	task automatic wreg(input int i, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		if (i == 4) begin
			mf = bus_fault_event;
			if (bus_fault_event[4])
				mt = master_port_resp;
		end else
			m[i] = d;
		bus(1'b1, 1'b1, ad(i), d, q, e);
		chk("write", {e, q[30:0]}, 32'h0);
	endtask
	task automatic flt(input logic [4:0] ev, input logic [1:0] rs);
		bus_fault_event = ev;
		master_port_resp = rs;
		mf |= ev;
		if (ev[4])
			mt = rs;
		@(posedge sys_clk);
		#1;
		bus_fault_event = 5'h0;
	endtask
	task automatic do_reset(input logic [6:0] s);
		rst_n = 1'b0;
		{tight_en_strap, retry_en_strap, merge_en_strap, periph_en_strap} = s;
		repeat (8) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		m[0] = {29'h0, s[3], s[1], s[5]};
		m[1] = {29'h0, s[4], s[2], s[6]};
		m[2] = {31'h0, s[0]};
		m[3] = 32'h0;
		m[5] = 32'h800;
		mf = 5'h0;
		mt = 2'h0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic comb();
		logic [31:0] r;
		logic [2:0]  rt;
		logic        dc;
		r = xs();
		tight_retry_in = r[1:0];
		tight_subchunk_write = r[3:2];
		{attr_write_back, attr_shared, attr_cacheable} = r[6:4];
		tight_region_hit = {r[8:7] == 2'h2, r[8:7] == 2'h1};
		periph_region_hit = r[8:7] == 2'h3;
		rt = {tight_region_hit & {m[1][0], m[0][0]}, periph_region_hit & m[2][0]};
		dc = r[4] && (!r[5] || m[3][0]);
		#2;
		chk("retry", tight_retry_honour, r[1:0] & {m[1][2], m[0][2]});
		chk("merge", tight_merge_req, r[3:2] & {m[1][1], m[0][1]});
		chk("route", {route_tight, route_periph}, rt);
		if (r[8:7] != 2'h0)
			chk("master", route_master, rt == 3'h0);
		chk("icache", icache_cacheable, r[4] && !r[5]);
		chk("dcache", dcache_cacheable, dc);
		if (dc)
			chk("wthru", dcache_write_through, m[3][2] || !r[6] || r[5]);
		chk("ecc", cache_check_on, !m[3][1]);
		chk("prio", {fairness_initial_value, traffic_priority, requester_select,
			fairness_counter_used}, {m[5][15:0], m[5][1:0] != 2'h3});
		@(posedge sys_clk);
		#1;
	endtask
	initial begin
		int          i;
		logic [31:0] q;
		logic        e;
		do_reset(7'h0);
		for (i = 0; i < 6; i++)
			rreg(i);
		comb();
		$display("test reset done");
		repeat (12) begin
			i = int'(xs() % 5);
			if (i == 4)
				i = 5;
			q = xs();
			q[11] = 1'b1;
			wreg(i, q);
			rreg(i);
			comb();
		end
		for (i = 0; i < 4; i++) begin
			wreg(5, {xs() | 32'h800} & 32'hFFFFFFFC | 32'(i));
			comb();
		end
		$display("test registers done");
		bus(1'b1, 1'b0, ad(3), ~m[3], q, e);
		chk("unpriv", {e, q[30:0]}, 32'h80000000);
		bus(1'b0, 1'b1, ad(6), 32'h0, q, e);
		chk("unmapped", {e, q[30:0]}, 32'h80000000);
		rreg(3);
		$display("test refusal done");
		for (i = 0; i < 4; i++) begin
			flt(5'(5'h10 | xs() & 5'hF), 2'(i));
			rreg(4);
			wreg(4, xs());
		end
		rreg(4);
		flt(5'h0D, 2'h2);
		rreg(4);
		bus_fault_event = 5'h01;
		wreg(4, 32'h0);
		rreg(4);
		clk_en = 1'b0;
		bus_fault_event = 5'h1E;
		@(posedge sys_clk);
		#1;
		bus_fault_event = 5'h0;
		clk_en = 1'b1;
		rreg(4);
		$display("test faults done");
		do_reset(7'(xs()));
		for (i = 0; i < 6; i++)
			rreg(i);
		comb();
		$display("test presets done");
		results();
	end
endmodule
`default_nettype wire
